// ==== logic/tsrb_defines.vh ====
// Purpose: Constants for the temperature monitor register bank
// Assumes: 8-bit register-select addressing
// Notes: Offsets are select values, not byte addresses
`ifndef TSRB_DEFINES_VH
`define TSRB_DEFINES_VH
// Read locations
`define TSRB_LOCAL_TEMP_MSB 8'h00
`define TSRB_REMOTE_TEMP_MSB 8'h01
`define TSRB_STATUS_FLAGS 8'h02
`define TSRB_CONFIG_RD 8'h03
`define TSRB_RATE_RD 8'h04
`define TSRB_LOCAL_UPPER_RD 8'h05
`define TSRB_LOCAL_LOWER_RD 8'h06
`define TSRB_REMOTE_UPPER_MSB_RD 8'h07
`define TSRB_REMOTE_LOWER_MSB_RD 8'h08
// Write-only aliases
`define TSRB_CONFIG_WR 8'h09
`define TSRB_RATE_WR 8'h0a
`define TSRB_LOCAL_UPPER_WR 8'h0b
`define TSRB_LOCAL_LOWER_WR 8'h0c
`define TSRB_REMOTE_UPPER_MSB_WR 8'h0d
`define TSRB_REMOTE_LOWER_MSB_WR 8'h0e
`define TSRB_SINGLE_CONV 8'h0f
// Shared locations; temperature LSBs and maker code are read-only
`define TSRB_REMOTE_TEMP_LSB 8'h10
`define TSRB_REMOTE_OFFSET_MSB 8'h11
`define TSRB_REMOTE_OFFSET_LSB 8'h12
`define TSRB_REMOTE_UPPER_LSB 8'h13
`define TSRB_REMOTE_LOWER_LSB 8'h14
`define TSRB_LOCAL_TEMP_LSB 8'h15
`define TSRB_REMOTE_CRIT 8'h19
`define TSRB_LOCAL_CRIT 8'h20
`define TSRB_CRIT_HYST 8'h21
`define TSRB_FAULT_COUNT 8'h22
`define TSRB_IDEALITY 8'h23
`define TSRB_FILTER 8'h24
`define TSRB_MAKER_CODE 8'hfe
// Reset values
`define TSRB_RST_ZERO 8'h00
`define TSRB_RST_RATE 8'h08
`define TSRB_RST_UPPER 8'h55
`define TSRB_RST_CRIT 8'h6e
`define TSRB_RST_HYST 8'h0a
`define TSRB_RST_FAULT 8'h01
// Arbitrary maker code value
`define TSRB_MAKER_VALUE 8'ha7
// Field masks
`define TSRB_CONFIG_MASK 8'he4
`define TSRB_RATE_MASK 8'h0f
`define TSRB_FAULT_MASK 8'h8e
`define TSRB_FAULT_FIXED 8'h01
`define TSRB_FILTER_MASK 8'h03
`define TSRB_NIBBLE_MASK 8'hf0
// Bus slave address, 7 bits
`define TSRB_SLAVE_ADDR 7'h4c
`endif

// ==== logic/tsrb_sync.v ====
// Purpose: Two-flop synchroniser for bus pins
// Assumes: Single clock CLK
// Notes: Output is the second flop only
`default_nettype none
module tsrb_sync (
    input wire clk,
    input wire reset_n,
    input wire d,
    output wire q
);
    reg s1_r;
    reg s2_r;
    // Pins idle high, so reset to one
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
        end
    end
    assign q = s2_r;
endmodule // tsrb_sync
`default_nettype wire

// ==== logic/tsrb_bank.v ====
// Purpose: Two-wire slave with pointer-addressed register bank
// Assumes: SCL slow against CLK; sampled with two flops
// Notes: Conversion results come in on a strobe from the measurement core
`default_nettype none
`include "tsrb_defines.vh"
module tsrb_bank (
    // Clock and reset
    input wire CLK,
    input wire RESET_N,
    // Two-wire pins, open drain
    input wire SCL_IN,
    input wire SDA_IN,
    output wire SDA_OUT,
    output wire SDA_OE,
    // Measurement core
    input wire CONV_DONE,
    input wire [11:0] LOCAL_RESULT,
    input wire [11:0] REMOTE_RESULT,
    input wire [7:0] STATUS_IN,
    output reg ONE_SHOT,
    // Settings to the measurement core
    output wire [7:0] CONFIG_OUT,
    output wire [3:0] RATE_OUT,
    output wire [7:0] LOCAL_UPPER_OUT,
    output wire [7:0] LOCAL_LOWER_OUT,
    output wire [11:0] REMOTE_UPPER_OUT,
    output wire [11:0] REMOTE_LOWER_OUT,
    output wire [11:0] REMOTE_OFFSET_OUT,
    output wire [7:0] REMOTE_CRIT_OUT,
    output wire [7:0] LOCAL_CRIT_OUT,
    output wire [7:0] HYST_OUT,
    output wire [7:0] FAULT_OUT,
    output wire [7:0] IDEALITY_OUT,
    output wire [1:0] FILTER_OUT
);
    // ************************************
    // Pin sampling
    // ************************************
    wire scl;
    wire sda;
    tsrb_sync u_scl (.clk(CLK), .reset_n(RESET_N), .d(SCL_IN), .q(scl));
    tsrb_sync u_sda (.clk(CLK), .reset_n(RESET_N), .d(SDA_IN), .q(sda));
    reg scl_d_r;
    reg sda_d_r;
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl;
            sda_d_r <= sda;
        end
    end
    wire scl_rise = scl & ~scl_d_r;
    wire scl_fall = ~scl & scl_d_r;
    wire start_c = scl & scl_d_r & sda_d_r & ~sda;
    wire stop_c = scl & scl_d_r & ~sda_d_r & sda;
    // ************************************
    // Registers
    // ************************************
    reg [7:0] sel_r;
    reg [7:0] config_r;
    reg [7:0] rate_r;
    reg [7:0] lupper_r;
    reg [7:0] llower_r;
    reg [7:0] rupper_msb_r;
    reg [7:0] rlower_msb_r;
    reg [7:0] rupper_lsb_r;
    reg [7:0] rlower_lsb_r;
    reg [7:0] roff_msb_r;
    reg [7:0] roff_lsb_r;
    reg [7:0] rcrit_r;
    reg [7:0] lcrit_r;
    reg [7:0] hyst_r;
    reg [7:0] fault_r;
    reg [7:0] ideal_r;
    reg [7:0] filter_r;
    reg [7:0] lt_msb_r;
    reg [7:0] lt_lsb_r;
    reg [7:0] rt_msb_r;
    reg [7:0] rt_lsb_r;
    // Freeze state per result: bit1 upper frozen, bit0 lower frozen
    reg [1:0] lfrz_r;
    reg [1:0] rfrz_r;
    assign CONFIG_OUT = config_r;
    assign RATE_OUT = rate_r[3:0];
    assign LOCAL_UPPER_OUT = lupper_r;
    assign LOCAL_LOWER_OUT = llower_r;
    assign REMOTE_UPPER_OUT = {rupper_msb_r, rupper_lsb_r[7:4]};
    assign REMOTE_LOWER_OUT = {rlower_msb_r, rlower_lsb_r[7:4]};
    assign REMOTE_OFFSET_OUT = {roff_msb_r, roff_lsb_r[7:4]};
    assign REMOTE_CRIT_OUT = rcrit_r;
    assign LOCAL_CRIT_OUT = lcrit_r;
    assign HYST_OUT = hyst_r;
    assign FAULT_OUT = fault_r;
    assign IDEALITY_OUT = ideal_r;
    assign FILTER_OUT = filter_r[1:0];
    // ************************************
    // Read decode
    // ************************************
    function [7:0] rd_mux;
        input [7:0] a;
        begin
            if (a == `TSRB_LOCAL_TEMP_MSB) rd_mux = lt_msb_r;
            else if (a == `TSRB_REMOTE_TEMP_MSB) rd_mux = rt_msb_r;
            else if (a == `TSRB_STATUS_FLAGS) rd_mux = STATUS_IN;
            else if (a == `TSRB_CONFIG_RD) rd_mux = config_r;
            else if (a == `TSRB_RATE_RD) rd_mux = rate_r;
            else if (a == `TSRB_LOCAL_UPPER_RD) rd_mux = lupper_r;
            else if (a == `TSRB_LOCAL_LOWER_RD) rd_mux = llower_r;
            else if (a == `TSRB_REMOTE_UPPER_MSB_RD) rd_mux = rupper_msb_r;
            else if (a == `TSRB_REMOTE_LOWER_MSB_RD) rd_mux = rlower_msb_r;
            else if (a == `TSRB_REMOTE_TEMP_LSB) rd_mux = rt_lsb_r;
            else if (a == `TSRB_REMOTE_OFFSET_MSB) rd_mux = roff_msb_r;
            else if (a == `TSRB_REMOTE_OFFSET_LSB) rd_mux = roff_lsb_r;
            else if (a == `TSRB_REMOTE_UPPER_LSB) rd_mux = rupper_lsb_r;
            else if (a == `TSRB_REMOTE_LOWER_LSB) rd_mux = rlower_lsb_r;
            else if (a == `TSRB_LOCAL_TEMP_LSB) rd_mux = lt_lsb_r;
            else if (a == `TSRB_REMOTE_CRIT) rd_mux = rcrit_r;
            else if (a == `TSRB_LOCAL_CRIT) rd_mux = lcrit_r;
            else if (a == `TSRB_CRIT_HYST) rd_mux = hyst_r;
            else if (a == `TSRB_FAULT_COUNT) rd_mux = fault_r;
            else if (a == `TSRB_IDEALITY) rd_mux = ideal_r;
            else if (a == `TSRB_FILTER) rd_mux = filter_r;
            else if (a == `TSRB_MAKER_CODE) rd_mux = `TSRB_MAKER_VALUE;
            else rd_mux = `TSRB_RST_ZERO; // One-shot and unmapped
        end
    endfunction
    // ************************************
    // Bus state machine
    // ************************************
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_WBYTE = 3'd3;
    localparam ST_WACK = 3'd4;
    localparam ST_RBYTE = 3'd5;
    localparam ST_RACK = 3'd6;
    reg [2:0] st_r;
    reg [3:0] cnt_r;
    reg [7:0] sh_r;
    reg first_r;
    reg drive_r;
    reg rd_done_r;
    assign SDA_OUT = 1'b0;
    assign SDA_OE = drive_r;
    // Byte in hand at the eighth rising edge
    wire [7:0] byte_in = {sh_r[6:0], sda};
    wire wr_strobe = (st_r == ST_WBYTE) && scl_rise && (cnt_r == 4'd7);
    wire [7:0] rd_byte = rd_mux(sel_r);
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= ST_IDLE;
            cnt_r <= 4'd0;
            sh_r <= 8'h00;
            first_r <= 1'b0;
            drive_r <= 1'b0;
            rd_done_r <= 1'b0;
            sel_r <= `TSRB_RST_ZERO;
        end else begin
            rd_done_r <= 1'b0;
            if (start_c) begin
                st_r <= ST_ADDR;
                cnt_r <= 4'd0;
                drive_r <= 1'b0;
            end else if (stop_c) begin
                st_r <= ST_IDLE;
                drive_r <= 1'b0;
            end else begin
                case (st_r)
                    ST_ADDR: begin
                        if (scl_rise) begin
                            sh_r <= byte_in;
                            cnt_r <= cnt_r + 4'd1;
                        end
                        if (scl_fall && cnt_r == 4'd8) begin
                            if (sh_r[7:1] == `TSRB_SLAVE_ADDR) begin
                                drive_r <= 1'b1;
                                st_r <= ST_AACK;
                            end else begin
                                st_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_fall) begin
                            cnt_r <= 4'd0;
                            if (sh_r[0]) begin
                                st_r <= ST_RBYTE;
                                sh_r <= rd_byte;
                                drive_r <= ~rd_byte[7];
                                rd_done_r <= 1'b1;
                            end else begin
                                st_r <= ST_WBYTE;
                                first_r <= 1'b1;
                                drive_r <= 1'b0;
                            end
                        end
                    end
                    ST_WBYTE: begin
                        if (scl_rise) begin
                            sh_r <= byte_in;
                            cnt_r <= cnt_r + 4'd1;
                        end
                        if (wr_strobe && first_r) sel_r <= byte_in;
                        if (scl_fall && cnt_r == 4'd8) begin
                            drive_r <= 1'b1;
                            st_r <= ST_WACK;
                        end
                    end
                    ST_WACK: begin
                        if (scl_fall) begin
                            drive_r <= 1'b0;
                            first_r <= 1'b0;
                            cnt_r <= 4'd0;
                            st_r <= ST_WBYTE;
                        end
                    end
                    ST_RBYTE: begin
                        if (scl_fall) begin
                            if (cnt_r == 4'd7) begin
                                drive_r <= 1'b0;
                                st_r <= ST_RACK;
                            end else begin
                                sh_r <= {sh_r[6:0], 1'b0};
                                drive_r <= ~sh_r[6];
                            end
                            cnt_r <= cnt_r + 4'd1;
                        end
                    end
                    ST_RACK: begin
                        // Master ack asks for the same register again
                        if (scl_rise && sda) begin
                            st_r <= ST_IDLE;
                        end else if (scl_fall) begin
                            cnt_r <= 4'd0;
                            sh_r <= rd_byte;
                            drive_r <= ~rd_byte[7];
                            rd_done_r <= 1'b1;
                            st_r <= ST_RBYTE;
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // ************************************
    // Register writes and one-shot
    // ************************************
    wire data_wr = wr_strobe && !first_r;
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            config_r <= `TSRB_RST_ZERO;
            rate_r <= `TSRB_RST_RATE;
            lupper_r <= `TSRB_RST_UPPER;
            llower_r <= `TSRB_RST_ZERO;
            rupper_msb_r <= `TSRB_RST_UPPER;
            rlower_msb_r <= `TSRB_RST_ZERO;
            rupper_lsb_r <= `TSRB_RST_ZERO;
            rlower_lsb_r <= `TSRB_RST_ZERO;
            roff_msb_r <= `TSRB_RST_ZERO;
            roff_lsb_r <= `TSRB_RST_ZERO;
            rcrit_r <= `TSRB_RST_CRIT;
            lcrit_r <= `TSRB_RST_CRIT;
            hyst_r <= `TSRB_RST_HYST;
            fault_r <= `TSRB_RST_FAULT;
            ideal_r <= `TSRB_RST_ZERO;
            filter_r <= `TSRB_RST_ZERO;
            ONE_SHOT <= 1'b0;
        end else begin
            ONE_SHOT <= 1'b0;
            if (data_wr) begin
                // Read-only and unmapped select values fall through
                if (sel_r == `TSRB_CONFIG_WR) config_r <= byte_in & `TSRB_CONFIG_MASK;
                else if (sel_r == `TSRB_RATE_WR) rate_r <= byte_in & `TSRB_RATE_MASK;
                else if (sel_r == `TSRB_LOCAL_UPPER_WR) lupper_r <= byte_in;
                else if (sel_r == `TSRB_LOCAL_LOWER_WR) llower_r <= byte_in;
                else if (sel_r == `TSRB_REMOTE_UPPER_MSB_WR) rupper_msb_r <= byte_in;
                else if (sel_r == `TSRB_REMOTE_LOWER_MSB_WR) rlower_msb_r <= byte_in;
                else if (sel_r == `TSRB_SINGLE_CONV) ONE_SHOT <= 1'b1;
                else if (sel_r == `TSRB_REMOTE_OFFSET_MSB) roff_msb_r <= byte_in;
                else if (sel_r == `TSRB_REMOTE_OFFSET_LSB)
                    roff_lsb_r <= byte_in & `TSRB_NIBBLE_MASK;
                else if (sel_r == `TSRB_REMOTE_UPPER_LSB)
                    rupper_lsb_r <= byte_in & `TSRB_NIBBLE_MASK;
                else if (sel_r == `TSRB_REMOTE_LOWER_LSB)
                    rlower_lsb_r <= byte_in & `TSRB_NIBBLE_MASK;
                else if (sel_r == `TSRB_REMOTE_CRIT) rcrit_r <= byte_in;
                else if (sel_r == `TSRB_LOCAL_CRIT) lcrit_r <= byte_in;
                else if (sel_r == `TSRB_CRIT_HYST) hyst_r <= byte_in;
                else if (sel_r == `TSRB_FAULT_COUNT)
                    fault_r <= (byte_in & `TSRB_FAULT_MASK) | `TSRB_FAULT_FIXED;
                else if (sel_r == `TSRB_IDEALITY) ideal_r <= byte_in;
                else if (sel_r == `TSRB_FILTER) filter_r <= byte_in & `TSRB_FILTER_MASK;
            end
        end
    end

    // ************************************
    // Result capture with read coherency
    // ************************************
    // Freeze follows each loaded read byte
    wire rd_lt_msb = rd_done_r && sel_r == `TSRB_LOCAL_TEMP_MSB;
    wire rd_lt_lsb = rd_done_r && sel_r == `TSRB_LOCAL_TEMP_LSB;
    wire rd_rt_msb = rd_done_r && sel_r == `TSRB_REMOTE_TEMP_MSB;
    wire rd_rt_lsb = rd_done_r && sel_r == `TSRB_REMOTE_TEMP_LSB;
    // Next freeze state for one result; other-register read clears
    function [1:0] frz_next;
        input [1:0] cur;
        input rd_any;
        input rd_msb;
        input rd_lsb;
        begin
            if (rd_msb) frz_next = cur[1] ? 2'b00 : 2'b01;
            else if (rd_lsb) frz_next = cur[0] ? 2'b00 : 2'b10;
            else if (rd_any) frz_next = 2'b00;
            else frz_next = cur;
        end
    endfunction
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            lt_msb_r <= `TSRB_RST_ZERO;
            lt_lsb_r <= `TSRB_RST_ZERO;
            rt_msb_r <= `TSRB_RST_ZERO;
            rt_lsb_r <= `TSRB_RST_ZERO;
            lfrz_r <= 2'b00;
            rfrz_r <= 2'b00;
        end else begin
            lfrz_r <= frz_next(lfrz_r, rd_done_r, rd_lt_msb, rd_lt_lsb);
            rfrz_r <= frz_next(rfrz_r, rd_done_r, rd_rt_msb, rd_rt_lsb);
            // Frozen halves skip the update so both halves share one conversion
            if (CONV_DONE) begin
                if (!lfrz_r[1]) lt_msb_r <= LOCAL_RESULT[11:4];
                if (!lfrz_r[0]) lt_lsb_r <= {LOCAL_RESULT[3:0], 4'h0};
                if (!rfrz_r[1]) rt_msb_r <= REMOTE_RESULT[11:4];
                if (!rfrz_r[0]) rt_lsb_r <= {REMOTE_RESULT[3:0], 4'h0};
            end
        end
    end
endmodule // tsrb_bank
`default_nettype wire

// ==== verification/tsrb_master_model.sv ====
// Purpose: Two-wire bus master standing in for the host side
// Assumes: Bus clock period of eight CLK cycles, pull-up on the data line
// Notes: Bus clock stands high between frames; released data reads high
`default_nettype none
module tsrb_master_model (
    // Clock
    input wire logic clk,
    // Bus lines
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q;
        repeat (2) @(negedge clk);
    endtask
    // Data falls while the clock is high
    task automatic start;
        q;
        sda_low = 1'b0;
        q;
        scl = 1'b1;
        q;
        sda_low = 1'b1;
        q;
        scl = 1'b0;
    endtask
    // Long high tail marks an idle bus
    task automatic stop;
        q;
        sda_low = 1'b1;
        q;
        scl = 1'b1;
        q;
        sda_low = 1'b0;
        repeat (3) q;
    endtask
    // Data moves mid low phase, away from edges
    task automatic bit_io(input logic b, output logic r);
        q;
        sda_low = ~b;
        q;
        scl = 1'b1;
        q;
        q;
        r = sda;
        scl = 1'b0;
    endtask
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic rx(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~more, r);
    endtask
endmodule // tsrb_master_model
`default_nettype wire

// ==== verification/tsrb_bank_properties.sv ====
// Purpose: Port-level properties of the register bank
// Assumes: Bus clock idles high between frames
// Notes: Eight high samples of the bus clock mean no frame is running
`default_nettype none
module tsrb_bank_properties (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Bus and settings
    input wire logic SCL_IN,
    input wire logic SDA_OE,
    input wire logic ONE_SHOT,
    input wire logic [7:0] LOCAL_UPPER_OUT,
    input wire logic [7:0] LOCAL_LOWER_OUT,
    input wire logic [11:0] REMOTE_UPPER_OUT,
    input wire logic [11:0] REMOTE_LOWER_OUT,
    input wire logic [11:0] REMOTE_OFFSET_OUT,
    input wire logic [7:0] REMOTE_CRIT_OUT,
    input wire logic [7:0] LOCAL_CRIT_OUT
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    // ****************
    // Reset values
    // ****************
    local_reset_a: assert property (
        $rose(RESET_N) |-> LOCAL_UPPER_OUT == 8'h55 && LOCAL_LOWER_OUT == 8'h00)
        else $error("Local limits wrong after reset");
    remote_reset_a: assert property (
        $rose(RESET_N) |-> REMOTE_UPPER_OUT == 12'h550 && REMOTE_LOWER_OUT == 12'h000
            && REMOTE_OFFSET_OUT == 12'h000)
        else $error("Remote settings wrong after reset");
    crit_reset_a: assert property (
        $rose(RESET_N) |-> REMOTE_CRIT_OUT == 8'h6e && LOCAL_CRIT_OUT == 8'h6e)
        else $error("Critical limits wrong after reset");
    // ****************
    // Bus side effects
    // ****************
    shot_pulse_a: assert property (ONE_SHOT |=> !ONE_SHOT)
        else $error("Conversion trigger longer than one cycle");
    idle_shot_a: assert property (SCL_IN [*8] |-> !ONE_SHOT)
        else $error("Conversion trigger with no bus write");
    idle_release_a: assert property (SCL_IN [*8] |-> !SDA_OE)
        else $error("Data line held on an idle bus");
    idle_limits_a: assert property (
        SCL_IN [*8] |=> $stable(LOCAL_UPPER_OUT) && $stable(REMOTE_UPPER_OUT))
        else $error("Upper limit changed on an idle bus");
    idle_other_a: assert property (
        SCL_IN [*8] |=> $stable(REMOTE_OFFSET_OUT) && $stable(LOCAL_LOWER_OUT)
            && $stable(REMOTE_CRIT_OUT) && $stable(LOCAL_CRIT_OUT))
        else $error("Setting changed on an idle bus");
endmodule // tsrb_bank_properties
bind tsrb_bank tsrb_bank_properties u_props (
    .CLK(CLK), .RESET_N(RESET_N), .SCL_IN(SCL_IN), .SDA_OE(SDA_OE), .ONE_SHOT(ONE_SHOT),
    .LOCAL_UPPER_OUT(LOCAL_UPPER_OUT), .LOCAL_LOWER_OUT(LOCAL_LOWER_OUT),
    .REMOTE_UPPER_OUT(REMOTE_UPPER_OUT), .REMOTE_LOWER_OUT(REMOTE_LOWER_OUT),
    .REMOTE_OFFSET_OUT(REMOTE_OFFSET_OUT), .REMOTE_CRIT_OUT(REMOTE_CRIT_OUT),
    .LOCAL_CRIT_OUT(LOCAL_CRIT_OUT)
);
`default_nettype wire

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench for the register bank
// Assumes: Master model runs the bus clock at 800 ns
// Notes: Random values come from a fixed-seed shift register
`default_nettype none
`include "tsrb_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK, RESET_N, CONV_DONE;
    logic [11:0] LOCAL_RESULT, REMOTE_RESULT;
    logic [7:0] STATUS_IN;
    wire SDA_OUT, SDA_OE, ONE_SHOT, scl, sda_low;
    wire [7:0] CONFIG_OUT, LOCAL_UPPER_OUT, LOCAL_LOWER_OUT, REMOTE_CRIT_OUT, LOCAL_CRIT_OUT;
    wire [7:0] HYST_OUT, FAULT_OUT, IDEALITY_OUT;
    wire [11:0] REMOTE_UPPER_OUT, REMOTE_LOWER_OUT, REMOTE_OFFSET_OUT;
    wire [3:0] RATE_OUT;
    wire [1:0] FILTER_OUT;
    // Open drain: either side pulls low
    wire sda = ~(sda_low | (SDA_OE & ~SDA_OUT));
    integer miscompares = 0;
    integer check_count = 0;
    integer shot_count = 0;
    logic [31:0] seed = 32'hf4875090;
    logic [7:0] sh [256];
    logic [7:0] rd_loc [16] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h11, 8'h12,
        8'h13, 8'h14, 8'h19, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
    logic [7:0] rst_val [16] = '{8'h00, 8'h08, 8'h55, 8'h00, 8'h55, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h6e, 8'h6e, 8'h0a, 8'h01, 8'h00, 8'h00};
    tsrb_bank dut (
        .CLK(CLK), .RESET_N(RESET_N), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
        .SDA_OE(SDA_OE), .CONV_DONE(CONV_DONE), .LOCAL_RESULT(LOCAL_RESULT),
        .REMOTE_RESULT(REMOTE_RESULT), .STATUS_IN(STATUS_IN), .ONE_SHOT(ONE_SHOT),
        .CONFIG_OUT(CONFIG_OUT), .RATE_OUT(RATE_OUT), .LOCAL_UPPER_OUT(LOCAL_UPPER_OUT),
        .LOCAL_LOWER_OUT(LOCAL_LOWER_OUT), .REMOTE_UPPER_OUT(REMOTE_UPPER_OUT),
        .REMOTE_LOWER_OUT(REMOTE_LOWER_OUT), .REMOTE_OFFSET_OUT(REMOTE_OFFSET_OUT),
        .REMOTE_CRIT_OUT(REMOTE_CRIT_OUT), .LOCAL_CRIT_OUT(LOCAL_CRIT_OUT),
        .HYST_OUT(HYST_OUT), .FAULT_OUT(FAULT_OUT), .IDEALITY_OUT(IDEALITY_OUT),
        .FILTER_OUT(FILTER_OUT)
    );
    tsrb_master_model m (.clk(CLK), .sda(sda), .scl(scl), .sda_low(sda_low));
    // ****************
    // Helpers
    // ****************
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        if (ONE_SHOT === 1'b1) shot_count <= shot_count + 1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_of(input logic [7:0] s, input logic [7:0] v);
        case (s)
            8'h03: return v & 8'he4;
            8'h04: return v & 8'h0f;
            8'h12, 8'h13, 8'h14: return v & 8'hf0;
            8'h22: return (v & 8'h8e) | 8'h01;
            8'h24: return v & 8'h03;
            default: return v;
        endcase
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wsel(input logic [7:0] s);
        logic ack;
        m.start;
        m.tx({`TSRB_SLAVE_ADDR, 1'b0}, ack);
        chk({7'h00, ack}, 8'h01);
        m.tx(s, ack);
    endtask
    task automatic wreg(input logic [7:0] s, input logic [7:0] d);
        logic ack;
        wsel(s);
        m.tx(d, ack);
        m.stop;
    endtask
    task automatic rcur(output logic [7:0] d);
        logic ack;
        m.start;
        m.tx({`TSRB_SLAVE_ADDR, 1'b1}, ack);
        m.rx(1'b0, d);
        m.stop;
    endtask
    // Select always written before a read
    task automatic rreg(input logic [7:0] s, output logic [7:0] d);
        wsel(s);
        m.stop;
        rcur(d);
    endtask
    task automatic conv(input logic [11:0] l, input logic [11:0] r);
        @(negedge CLK);
        LOCAL_RESULT = l;
        REMOTE_RESULT = r;
        CONV_DONE = 1'b1;
        @(negedge CLK);
        CONV_DONE = 1'b0;
    endtask
    initial begin
        repeat (90000) @(posedge CLK);
        miscompares++;
        conclude;
    end
    // ****************
    // Sequence
    // ****************
    initial begin
        logic [7:0] d, v;
        logic [11:0] l1, r1;
        logic ack;
        integer n;
        RESET_N = 1'b0;
        CONV_DONE = 1'b0;
        LOCAL_RESULT = 12'h000;
        REMOTE_RESULT = 12'h000;
        STATUS_IN = seed[7:0];
        repeat (8) @(posedge CLK);
        @(negedge CLK) RESET_N = 1'b1;
        rcur(d);
        chk(d, 8'h00);
        conv(12'h0a1, 12'hfff);
        rcur(d);
        chk(d, 8'h0a);
        rreg(8'h15, d);
        chk(d, 8'h00);
        seed = lfsr(seed);
        l1 = seed[11:0];
        r1 = seed[27:16];
        conv(l1, r1);
        // Upper byte first, lower byte in the next read
        rreg(8'h01, d);
        chk(d, r1[11:4]);
        rreg(8'h10, d);
        chk(d, {r1[3:0], 4'h0});
        rreg(8'h15, d);
        chk(d, {l1[3:0], 4'h0});
        conv(~l1, r1);
        rreg(8'h00, d);
        chk(d, l1[11:4]);
        rreg(8'h01, d);
        rreg(8'h05, d);
        conv(l1, ~r1);
        rreg(8'h10, d);
        chk(d, {~r1[3:0], 4'h0});
        wreg(8'h00, ~l1[11:4]);
        rreg(8'h00, d);
        chk(d, l1[11:4]);
        for (int i = 0; i < 16; i++) begin
            rreg(rd_loc[i], d);
            chk(d, rst_val[i]);
            seed = lfsr(seed);
            v = seed[7:0];
            sh[rd_loc[i]] = exp_of(rd_loc[i], v);
            wreg(i < 6 ? rd_loc[i] + 8'h06 : rd_loc[i], v);
            rreg(rd_loc[i], d);
            chk(d, sh[rd_loc[i]]);
            if (i < 6) begin
                wreg(rd_loc[i], ~v);
                rreg(rd_loc[i], d);
                chk(d, sh[rd_loc[i]]);
            end
        end
        chk(LOCAL_UPPER_OUT, sh[8'h05]);
        chk(LOCAL_LOWER_OUT, sh[8'h06]);
        chk(REMOTE_UPPER_OUT[11:4], sh[8'h07]);
        chk({REMOTE_UPPER_OUT[3:0], 4'h0}, sh[8'h13]);
        chk(REMOTE_LOWER_OUT[11:4], sh[8'h08]);
        chk({REMOTE_LOWER_OUT[3:0], 4'h0}, sh[8'h14]);
        chk(REMOTE_OFFSET_OUT[11:4], sh[8'h11]);
        chk({REMOTE_OFFSET_OUT[3:0], 4'h0}, sh[8'h12]);
        chk(REMOTE_CRIT_OUT, sh[8'h19]);
        chk(LOCAL_CRIT_OUT, sh[8'h20]);
        chk(CONFIG_OUT, sh[8'h03]);
        chk({4'h0, RATE_OUT}, sh[8'h04]);
        chk(HYST_OUT, sh[8'h21]);
        chk(FAULT_OUT, sh[8'h22]);
        chk(IDEALITY_OUT, sh[8'h23]);
        chk({6'h00, FILTER_OUT}, sh[8'h24]);
        wreg(8'hff, 8'h5a);
        rreg(8'hff, d);
        chk(d, 8'h00);
        chk(LOCAL_UPPER_OUT, sh[8'h05]);
        rreg(8'hfe, d);
        chk(d, `TSRB_MAKER_VALUE);
        wsel(8'h02);
        m.stop;
        m.start;
        m.tx({`TSRB_SLAVE_ADDR, 1'b1}, ack);
        m.rx(1'b1, d);
        m.rx(1'b0, v);
        m.stop;
        chk(d, STATUS_IN);
        chk(v, STATUS_IN);
        rreg(8'h0f, d);
        chk(d, 8'h00);
        m.start;
        m.tx({`TSRB_SLAVE_ADDR ^ 7'h01, 1'b0}, ack);
        m.stop;
        chk({7'h00, ack}, 8'h00);
        n = shot_count;
        wsel(8'h0f);
        m.stop;
        seed = lfsr(seed);
        wreg(8'h0f, seed[7:0]);
        wreg(8'h0f, 8'h00);
        chk(8'(shot_count - n), 8'h02);
        conclude;
    end
endmodule // testbench
`default_nettype wire
